// ==== hdl/ledfs_ahb_slave.sv ====
// AHB-Lite slave front end: zero wait states, OKAY only
`timescale 1ns/1ns
module ledfs_ahb_slave (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire ledfs_pkg::ledfs_ahb_req_t ahb_req,
    input  wire logic [31:0]            rd_data,
    output logic [7:0]                  rd_addr,
    output ledfs_pkg::ledfs_reg_wr_t    reg_wr,
    output logic [31:0]                 hrdata,
    output logic                        hreadyout,
    output logic                        hresp
);
    typedef struct packed {
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
    } ledfs_ahb_st_t;

    ledfs_ahb_st_t st_q;
    ledfs_ahb_st_t st_d;
    logic          take;

    // Read data is sampled in the address phase so hrdata comes from a flop
    always_comb begin
        st_d = st_q;
        take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
        st_d.wr_pend = take && ahb_req.hwrite;
        if (take) begin
            st_d.wr_addr = ahb_req.haddr[7:0];
            if (!ahb_req.hwrite) begin
                st_d.rdata = rd_data;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_addr     = ahb_req.haddr[7:0];
    assign reg_wr.en   = st_q.wr_pend;
    assign reg_wr.addr = st_q.wr_addr;
    assign reg_wr.data = ahb_req.hwdata;
    assign hrdata      = st_q.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
endmodule // ledfs_ahb_slave

// ==== hdl/ledfs_params.svh ====
// Constants of the LED driver fault supervisor: offsets, fields, resets, timing
`ifndef LEDFS_PARAMS_SVH
`define LEDFS_PARAMS_SVH

`define LEDFS_CLK_PERIOD_NS   20
`define LEDFS_MASK_TIME_NS    15000
`define LEDFS_FDG_TIME_NS     20000
`define LEDFS_HICCUP_TIME_NS  1000000
`define LEDFS_SW_PERIOD_NS    2000
`define LEDFS_REG_TIMER_SW    256
`define LEDFS_MASK_CYC   ((`LEDFS_MASK_TIME_NS + `LEDFS_CLK_PERIOD_NS - 1) / `LEDFS_CLK_PERIOD_NS)
`define LEDFS_FDG_CYC    ((`LEDFS_FDG_TIME_NS + `LEDFS_CLK_PERIOD_NS - 1) / `LEDFS_CLK_PERIOD_NS)
`define LEDFS_HICCUP_CYC (`LEDFS_HICCUP_TIME_NS / `LEDFS_CLK_PERIOD_NS)
`define LEDFS_SW_CYC     (`LEDFS_SW_PERIOD_NS / `LEDFS_CLK_PERIOD_NS)

`define LEDFS_OFS_CTRL    8'h00
`define LEDFS_OFS_STATUS  8'h04
`define LEDFS_OFS_CAUSE   8'h08
`define LEDFS_CTRL_RESET  32'h0000_0001
`define LEDFS_CTRL_RUN    0
`define LEDFS_ST_FLAG     0
`define LEDFS_ST_SWITCH   1
`define LEDFS_ST_HELD     2
`define LEDFS_ST_MASK     3
`define LEDFS_ST_MODE_LO  4
`define LEDFS_CAUSE_OCP   0
`define LEDFS_CAUSE_CSOV  1
`define LEDFS_CAUSE_OPEN  2
`define LEDFS_CAUSE_SHORT 3
`define LEDFS_CAUSE_TON   4
`define LEDFS_CAUSE_VOUT  5
`define LEDFS_CAUSE_VCC   6
`define LEDFS_CAUSE_BOOT  7

`endif

// ==== hdl/ledfs_pkg.sv ====
// Types shared by the LED driver fault supervisor files
package ledfs_pkg;

    typedef enum logic [2:0] {
        LEDFS_OFF      = 3'h0,
        LEDFS_RUN      = 3'h1,
        LEDFS_HICCUP   = 3'h2,
        LEDFS_TON_WAIT = 3'h3,
        LEDFS_LATCHED  = 3'h4
    } ledfs_mode_t;

    typedef struct packed {
        logic vin_mask_threshold_input;
        logic analog_dim_input;
        logic vout_low;
        logic sense_low_max_duty;
        logic string_short;
        logic switch_overcurrent_trip;
        logic sense_overvoltage;
        logic boot_undervoltage;
        logic on_time_set_pin_fault;
        logic regulator_overcurrent;
    } ledfs_sense_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ledfs_ahb_req_t;

    typedef struct packed {
        logic        en;
        logic [7:0]  addr;
        logic [31:0] data;
    } ledfs_reg_wr_t;

endpackage

// ==== hdl/ledfs_supervisor.sv ====
// Fault supervisor of a constant-current buck LED driver with AHB-Lite registers
`timescale 1ns/1ns
`include "ledfs_params.svh"
module ledfs_supervisor #(
    parameter logic [15:0] HICCUP_CYCLES = 16'(`LEDFS_HICCUP_CYC)
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire logic                   pwm_in,
    input  wire logic                   enable_in,
    input  wire ledfs_pkg::ledfs_sense_t sense,
    output logic                        fault_flag_low,
    output logic                        switch_enable,
    output logic                        min_on_time_mode,
    output logic                        hiccup_active
);
    localparam logic [15:0] MASK_LIMIT = 16'(`LEDFS_MASK_CYC);
    localparam logic [15:0] FDG_LIMIT  = 16'(`LEDFS_FDG_CYC);
    localparam logic [15:0] REG_LIMIT  = 16'(`LEDFS_REG_TIMER_SW);
    localparam logic [6:0]  SW_LAST    = 7'(`LEDFS_SW_CYC - 1);

    typedef struct packed {
        ledfs_pkg::ledfs_mode_t mode;
        logic                   pwm_q;
        logic [6:0]             sw_div;
        logic                   held;
        logic                   flag;
        logic                   switching;
        logic                   min_on;
        logic                   ctrl_run;
        logic [7:0]             cause;
    } ledfs_core_st_t;

    ledfs_core_st_t           st_q;
    ledfs_core_st_t           st_d;
    ledfs_pkg::ledfs_ahb_req_t ahb_req;
    ledfs_pkg::ledfs_reg_wr_t  reg_wr;
    logic [7:0]               rd_addr;
    logic [31:0]              rd_data;
    logic                     sw_tick;
    logic                     pwm_rise;
    logic                     enabled;
    logic                     mask_expired;
    logic                     det_en;
    logic                     open_cand;
    logic                     short_cand;
    logic                     open_fdg_done;
    logic                     short_fdg_done;
    logic                     open_conf;
    logic                     short_conf;
    logic                     hiccup_done;
    logic                     reg_done;
    logic                     hiccup_load;
    logic                     hard_trip;
    logic                     vout_short;
    logic                     flag_now;
    logic [7:0]               cause_set;

    assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                       hsize: hsize, hwdata: hwdata, hready: hready};

    ledfs_ahb_slave u_ahb (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ahb_req   (ahb_req),
        .rd_data   (rd_data),
        .rd_addr   (rd_addr),
        .reg_wr    (reg_wr),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    // Comparator outputs arrive as logic levels: high means the named condition is present
    assign enabled  = enable_in && st_q.ctrl_run;
    assign pwm_rise = pwm_in && !st_q.pwm_q;
    assign sw_tick  = (st_q.sw_div == 7'h00);

    // Mask restarts on every PWM rising edge; short pulses never see string open or short detection
    ledfs_timer u_mask (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (pwm_rise),
        .tick    (1'b1),
        .limit   (MASK_LIMIT),
        .expired (mask_expired)
    );

    assign det_en     = pwm_in && !pwm_rise && mask_expired
                        && st_q.mode == ledfs_pkg::LEDFS_RUN;
    // Open detection needs both the VIN mask comparator and dim level high
    assign open_cand  = sense.sense_low_max_duty && sense.vin_mask_threshold_input
                        && sense.analog_dim_input && det_en;
    assign short_cand = sense.string_short && sense.analog_dim_input
                        && det_en;

    // Any gap in the condition reloads the deglitch counter
    ledfs_timer u_open_fdg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (!open_cand),
        .tick    (1'b1),
        .limit   (FDG_LIMIT),
        .expired (open_fdg_done)
    );

    ledfs_timer u_short_fdg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (!short_cand),
        .tick    (1'b1),
        .limit   (FDG_LIMIT),
        .expired (short_fdg_done)
    );

    assign open_conf  = open_cand && open_fdg_done;
    assign short_conf = short_cand && short_fdg_done;

    // Shared retry timer: hiccup period and on-time pin recheck interval
    ledfs_timer u_hiccup (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (hiccup_load),
        .tick    (1'b1),
        .limit   (HICCUP_CYCLES),
        .expired (hiccup_done)
    );

    // Counts switching cycles of regulation since the last restart
    ledfs_timer u_reg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (st_q.mode != ledfs_pkg::LEDFS_RUN),
        .tick    (sw_tick),
        .limit   (REG_LIMIT),
        .expired (reg_done)
    );

    // Trips that stop switching; an open capacitor has no input at all
    // because no member of ledfs_sense_t reports the output capacitor
    assign hard_trip  = sense.switch_overcurrent_trip
                        || sense.sense_overvoltage
                        || open_conf;
    assign vout_short = sense.vout_low && sense.analog_dim_input;

    always_comb begin
        st_d        = st_q;
        hiccup_load = 1'b0;
        cause_set   = 8'h00;
        flag_now    = st_q.flag;
        st_d.pwm_q  = pwm_in;
        st_d.sw_div = sw_tick ? SW_LAST : st_q.sw_div - 7'h01;

        unique case (st_q.mode)
            ledfs_pkg::LEDFS_OFF: begin
                if (enabled) begin
                    st_d.mode = ledfs_pkg::LEDFS_RUN;
                end
            end
            ledfs_pkg::LEDFS_RUN: begin
                if (sense.regulator_overcurrent) begin
                    st_d.mode = ledfs_pkg::LEDFS_LATCHED;
                end else if (sense.on_time_set_pin_fault) begin
                    st_d.mode   = ledfs_pkg::LEDFS_TON_WAIT;
                    hiccup_load = 1'b1;
                end else if (hard_trip) begin
                    st_d.mode   = ledfs_pkg::LEDFS_HICCUP;
                    hiccup_load = 1'b1;
                end
            end
            ledfs_pkg::LEDFS_HICCUP: begin
                // Retry restarts regulation; a persisting fault trips again
                if (sense.regulator_overcurrent) begin
                    st_d.mode = ledfs_pkg::LEDFS_LATCHED;
                end else if (hiccup_done) begin
                    st_d.mode = ledfs_pkg::LEDFS_RUN;
                end
            end
            ledfs_pkg::LEDFS_TON_WAIT: begin
                if (sense.regulator_overcurrent) begin
                    st_d.mode = ledfs_pkg::LEDFS_LATCHED;
                end else if (hiccup_done) begin
                    if (sense.on_time_set_pin_fault) begin
                        hiccup_load = 1'b1;
                    end else begin
                        st_d.mode = ledfs_pkg::LEDFS_RUN;
                    end
                end
            end
            ledfs_pkg::LEDFS_LATCHED: begin
                // Only dropping enable_in or clearing the CTRL run bit brings the device back
                st_d.mode = ledfs_pkg::LEDFS_LATCHED;
            end
            default: begin
                st_d.mode = ledfs_pkg::LEDFS_OFF;
            end
        endcase
        if (!enabled) begin
            st_d.mode   = ledfs_pkg::LEDFS_OFF;
            hiccup_load = 1'b0;
        end

        // Latched fault: set by confirmations and retry modes
        if (open_conf || short_conf) begin
            st_d.held = 1'b1;
        end else if (st_d.mode == ledfs_pkg::LEDFS_HICCUP
                     || st_d.mode == ledfs_pkg::LEDFS_TON_WAIT) begin
            st_d.held = 1'b1;
        end else if (st_q.mode == ledfs_pkg::LEDFS_RUN && reg_done && det_en
                     && !sense.sense_low_max_duty && !sense.string_short) begin
            st_d.held = 1'b0;
        end
        if (st_d.mode == ledfs_pkg::LEDFS_OFF || st_d.mode == ledfs_pkg::LEDFS_LATCHED) begin
            st_d.held = 1'b0;
        end

        // Output short clears by itself once the output recovers
        if (pwm_in) begin
            flag_now = st_d.held || (vout_short
                       && st_q.mode == ledfs_pkg::LEDFS_RUN);
        end
        if (st_d.mode == ledfs_pkg::LEDFS_OFF || st_d.mode == ledfs_pkg::LEDFS_LATCHED) begin
            flag_now = 1'b0;
        end
        st_d.flag = flag_now;

        // Bootstrap undervoltage stops switching without any flag
        st_d.switching = st_d.mode == ledfs_pkg::LEDFS_RUN && !hard_trip
                         && !sense.on_time_set_pin_fault
                         && !sense.regulator_overcurrent
                         && !sense.boot_undervoltage && pwm_in;
        // Shorted output keeps switching at minimum on-time, no hiccup
        st_d.min_on    = st_d.switching && vout_short;

        cause_set[`LEDFS_CAUSE_OCP]   = sense.switch_overcurrent_trip;
        cause_set[`LEDFS_CAUSE_CSOV]  = sense.sense_overvoltage;
        cause_set[`LEDFS_CAUSE_OPEN]  = open_conf;
        cause_set[`LEDFS_CAUSE_SHORT] = short_conf;
        cause_set[`LEDFS_CAUSE_TON]   = sense.on_time_set_pin_fault && enabled;
        cause_set[`LEDFS_CAUSE_VOUT]  = vout_short && pwm_in;
        cause_set[`LEDFS_CAUSE_VCC]   = sense.regulator_overcurrent && enabled;
        cause_set[`LEDFS_CAUSE_BOOT]  = sense.boot_undervoltage && enabled;

        // Write one to clear; a new event in the same cycle wins
        if (reg_wr.en && reg_wr.addr == `LEDFS_OFS_CAUSE) begin
            st_d.cause = st_q.cause & ~reg_wr.data[7:0];
        end
        st_d.cause = st_d.cause | cause_set;
        if (reg_wr.en && reg_wr.addr == `LEDFS_OFS_CTRL) begin
            st_d.ctrl_run = reg_wr.data[`LEDFS_CTRL_RUN];
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            `LEDFS_OFS_CTRL: begin
                rd_data[`LEDFS_CTRL_RUN] = st_q.ctrl_run;
            end
            `LEDFS_OFS_STATUS: begin
                rd_data[`LEDFS_ST_FLAG]   = st_q.flag;
                rd_data[`LEDFS_ST_SWITCH] = st_q.switching;
                rd_data[`LEDFS_ST_HELD]   = st_q.held;
                rd_data[`LEDFS_ST_MASK]   = !mask_expired;
                rd_data[`LEDFS_ST_MODE_LO +: 3] = st_q.mode;
            end
            `LEDFS_OFS_CAUSE: begin
                rd_data[7:0] = st_q.cause;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q          <= '0;
            st_q.mode     <= ledfs_pkg::LEDFS_OFF;
            st_q.ctrl_run <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign fault_flag_low   = !st_q.flag;
    assign switch_enable    = st_q.switching;
    assign min_on_time_mode = st_q.min_on;
    assign hiccup_active    = st_q.mode == ledfs_pkg::LEDFS_HICCUP;
endmodule // ledfs_supervisor

// ==== hdl/ledfs_timer.sv ====
// Down counter that reloads on demand and reports expiry
`timescale 1ns/1ns
module ledfs_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        load,
    input  wire logic        tick,
    input  wire logic [15:0] limit,
    output logic             expired
);
    typedef struct packed {
        logic [15:0] cnt;
    } ledfs_tmr_st_t;

    ledfs_tmr_st_t st_q;
    ledfs_tmr_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.cnt = limit;
        end else if (tick && st_q.cnt != 16'h0000) begin
            st_d.cnt = st_q.cnt - 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Idle counter reads as expired so nothing is masked after reset
    assign expired = (st_q.cnt == 16'h0000);
endmodule // ledfs_timer

// ==== testbench/ledfs_ctrl_model.sv ====
// Lighting control module model: drives PWM and enable, watches the flag
`timescale 1ns/1ns
module ledfs_ctrl_model (
    input  wire logic hclk,
    input  wire logic pwm_req,
    input  wire logic en_req,
    input  wire logic fault_flag_low,
    output logic      pwm_in,
    output logic      enable_in,
    output logic      fault_seen
);
    initial begin
        pwm_in = 1'b0;
        enable_in = 1'b0;
        fault_seen = 1'b0;
    end
    always @(posedge hclk) begin
        pwm_in <= pwm_req;
        enable_in <= en_req;
        fault_seen <= fault_seen | ~fault_flag_low;
    end
endmodule // ledfs_ctrl_model

// ==== testbench/ledfs_props.sv ====
// Concurrent checks on the fault supervisor outputs
`timescale 1ns/1ns
module ledfs_props #(
    parameter logic [15:0] HICCUP_CYCLES = 16'h0028
) (
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    pwm_in,
    input wire ledfs_pkg::ledfs_sense_t sense,
    input wire logic                    fault_flag_low,
    input wire logic                    switch_enable,
    input wire logic                    hiccup_active
);
    localparam int FDG = 1000;
    localparam int HMAX = int'(HICCUP_CYCLES) + 4;
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic        hard;
    logic        cand;
    assign cand = sense.string_short | sense.sense_low_max_duty;
    assign hard = sense.switch_overcurrent_trip | sense.sense_overvoltage
                | sense.on_time_set_pin_fault | (sense.vout_low & sense.analog_dim_input);
    // Candidate run length while PWM is high; saturates so it cannot wrap
    assign cnt_d = (!pwm_in || !cand) ? 11'h000 : (&cnt_q) ? cnt_q : cnt_q + 11'h001;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 11'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_trip;
        (sense.switch_overcurrent_trip || sense.sense_overvoltage) && switch_enable && pwm_in
            && !sense.regulator_overcurrent;
    endsequence
    sequence s_quiet_rise;
        $rose(pwm_in) && fault_flag_low ##1 (!hard)[*8];
    endsequence
    AST_FLAG_HELD: assert property (!pwm_in |=> $stable(fault_flag_low))
        else $error("flag moved while pwm low");
    AST_MASK_QUIET: assert property (s_quiet_rise |-> fault_flag_low)
        else $error("flag fell inside mask");
    AST_DEGLITCH: assert property ($fell(fault_flag_low) && !$past(hard) |-> cnt_q >= FDG)
        else $error("string fault flagged before deglitch");
    AST_RELEASE_PWM: assert property ($rose(fault_flag_low) |-> $past(pwm_in))
        else $error("flag released with pwm low");
    AST_TRIP: assert property (s_trip |=> hiccup_active && !switch_enable && !fault_flag_low)
        else $error("hard trip not handled");
    AST_HICCUP_LEN: assert property ($rose(hiccup_active) |-> hiccup_active[*8] ##[1:HMAX] !hiccup_active)
        else $error("hiccup period wrong");
    AST_REG_OC: assert property (sense.regulator_overcurrent && fault_flag_low && !hard && !cand
        |=> fault_flag_low && !switch_enable)
        else $error("regulator overcurrent handling wrong");
    AST_BOOT_UV: assert property (sense.boot_undervoltage |=> !switch_enable)
        else $error("switching with boot undervoltage");
endmodule // ledfs_props
bind ledfs_supervisor ledfs_props #(.HICCUP_CYCLES(HICCUP_CYCLES)) ledfs_props_inst (
    .hclk, .hresetn, .pwm_in, .sense, .fault_flag_low, .switch_enable, .hiccup_active);

// ==== testbench/testbench.sv ====
// Self-checking bench for the LED driver fault supervisor
`timescale 1ns/1ns
module testbench;
    logic                    hclk = 1'b0;
    logic                    hresetn = 1'b0;
    logic                    hsel = 1'b0;
    logic [31:0]             haddr = 32'h0;
    logic [1:0]              htrans = 2'h0;
    logic                    hwrite = 1'b0;
    logic [31:0]             hwdata = 32'h0;
    logic [31:0]             hrdata, rd;
    logic                    hreadyout, hresp, fault_flag_low, switch_enable, min_on, hiccup;
    logic                    pwm_req = 1'b1, en_req = 1'b1, pwm_in, enable_in, seen;
    ledfs_pkg::ledfs_sense_t sense = '0;
    logic [31:0]             rng = 32'd64168;
    int                      num_errors = 0, tests_run = 0;
    int                      trips[$] = '{4, 3, 1};
    always #10 hclk = ~hclk;
    ledfs_supervisor #(.HICCUP_CYCLES(16'h0028)) ledfs_supervisor_inst (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .pwm_in, .enable_in, .sense, .fault_flag_low, .switch_enable,
        .min_on_time_mode(min_on), .hiccup_active(hiccup));
    ledfs_ctrl_model ledfs_ctrl_model_inst (.hclk, .pwm_req, .en_req, .fault_flag_low, .pwm_in,
        .enable_in, .fault_seen(seen));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Xorshift step; a fixed seed keeps every run repeatable
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Bounded wait for a flag level, then compare
    task automatic flag_to(input logic e, input int n);
        for (int i = 0; i < n && fault_flag_low !== e; i++) cyc(1);
        chk(fault_flag_low, e, "flag");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1900000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        cyc(10);
        hresetn <= 1'b1;
        cyc(2);
        sense.vin_mask_threshold_input <= 1'b1;
        sense.analog_dim_input <= 1'b1;
        ahb(0, 8'h00, 0);
        chk(rd, 32'h1, "ctrl");
        ahb(0, 8'h0c, 0);
        chk(rd, 32'h0, "unmapped");
        chk(switch_enable, 1'b1, "switching");
        ahb(1, 8'h00, 32'h0);
        cyc(3);
        chk(switch_enable, 1'b0, "run off");
        ahb(1, 8'h00, 32'h1);
        // Random short glitches never last the deglitch span
        repeat (2000) begin
            cyc(1);
            rng = xs(rng);
            sense.string_short <= rng[3];
        end
        chk(fault_flag_low, 1'b1, "glitch");
        sense.vin_mask_threshold_input <= 1'b0;
        sense.sense_low_max_duty <= 1'b1;
        sense.string_short <= 1'b0;
        cyc(2500);
        chk(fault_flag_low, 1'b1, "vin masked");
        chk(switch_enable, 1'b1, "max duty");
        sense.vin_mask_threshold_input <= 1'b1;
        sense.sense_low_max_duty <= 1'b0;
        sense.analog_dim_input <= 1'b0;
        sense.string_short <= 1'b1;
        cyc(2500);
        chk(fault_flag_low, 1'b1, "dim masked");
        pwm_req <= 1'b0;
        sense.analog_dim_input <= 1'b1;
        repeat (4) begin
            cyc(300);
            pwm_req <= 1'b1;
            cyc(700);
            pwm_req <= 1'b0;
        end
        chk(fault_flag_low, 1'b1, "short pulses");
        cyc(300);
        pwm_req <= 1'b1;
        cyc(1600);
        chk(fault_flag_low, 1'b1, "early");
        flag_to(1'b0, 300);
        ahb(0, 8'h08, 0);
        chk(rd, 32'h8, "cause short");
        ahb(0, 8'h04, 0);
        chk(rd, 32'h17, "status");
        pwm_req <= 1'b0;
        sense.string_short <= 1'b0;
        cyc(3000);
        chk(fault_flag_low, 1'b0, "held");
        pwm_req <= 1'b1;
        flag_to(1'b1, 30000);
        ahb(1, 8'h08, 32'hff);
        ahb(0, 8'h08, 0);
        chk(rd, 32'h0, "cause clear");
        sense.regulator_overcurrent <= 1'b1;
        cyc(3);
        sense.regulator_overcurrent <= 1'b0;
        cyc(50);
        chk(switch_enable, 1'b0, "latched off");
        chk(fault_flag_low, 1'b1, "silent");
        en_req <= 1'b0;
        cyc(3);
        en_req <= 1'b1;
        cyc(5);
        chk(switch_enable, 1'b1, "restart");
        sense.boot_undervoltage <= 1'b1;
        cyc(3);
        chk({switch_enable, fault_flag_low}, 32'h1, "boot uv");
        sense.boot_undervoltage <= 1'b0;
        sense.vout_low <= 1'b1;
        cyc(100);
        chk({min_on, hiccup, fault_flag_low}, 32'h4, "out short");
        sense.vout_low <= 1'b0;
        cyc(3);
        chk({min_on, switch_enable}, 32'h1, "resume");
        foreach (trips[i]) begin
            sense[trips[i]] <= 1'b1;
            cyc(1);
            sense[trips[i]] <= 1'b0;
            cyc(1);
            chk({switch_enable, fault_flag_low}, 32'h0, "trip");
            chk(hiccup, trips[i] != 1, "hiccup");
            for (int k = 0; k < 200 && switch_enable !== 1'b1; k++) cyc(1);
            chk(switch_enable, 1'b1, "retry");
        end
        cyc(25000);
        chk(fault_flag_low, 1'b0, "regulation timer");
        flag_to(1'b1, 2000);
        ahb(0, 8'h08, 0);
        chk(rd, 32'hf3, "cause all");
        chk({seen, hresp}, 32'h2, "seen");
        tally_and_finish();
    end
endmodule // testbench
